// >>> dv/dlc_core_bench.sv
// Self-checking bench for the DAC latch and reset control core
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin mismatches++; \
	$display("Error %s expected %0h seen %0h", n, e, s); end end
module dlc_core_bench;
	logic clk_i = 0, rst_b_i = 0, supply_drop_reset_event_i = 0, output_update_latch_n_i = 0;
	logic high_voltage_program_pin_i = 0, address_select_pin_zero_i = 0, address_select_pin_one_i = 0;
	logic nv_programmed_i = 0, wr_en_i = 0, clr_status_i = 0, nv_wr_req_i = 0, go = 0;
	logic [11:0] nv_wiper0_i = 0, nv_wiper1_i = 0, act_wiper0_o, act_wiper1_o;
	logic [3:0] nv_ref_sel_i = 0, nv_pd_sel_i = 0, act_ref_sel_o, act_pd_sel_o;
	logic [1:0] nv_gain_i = 0, nv_addr_bits_i = 0, act_gain_o;
	logic [4:0] wr_addr_i = 0, rd_addr_i = 0, addr_ptr_o;
	logic [15:0] wr_data_i = 0, rd_data_o, r;
	logic sda_o, sda_oe_o, scl_oe_o, reset_status_o, serial_ready_o, nv_wr_en_o, analog_on_o;
	logic [6:0] target_addr_o;
	logic [33:0] vol, act;
	logic [4:0] adr [0:5] = '{5'h00, 5'h01, 5'h08, 5'h09, 5'h0a, 5'h03};
	wire [33:0] act_all = {act_wiper0_o, act_wiper1_o, act_ref_sel_o, act_pd_sel_o, act_gain_o};
	wire host_scl, host_sda;
	// Open-drain wires with pull-ups
	wire scl_i = host_scl & ~scl_oe_o;
	wire sda_i = host_sda & ~(sda_oe_o & ~sda_o);
	integer cycles = 0, mismatches = 0, num_checks = 0, i;
	dlc_core #(.PORD_CYCLES(4)) u_dlc_core (.*);
	dlc_i2c_host u_dlc_i2c_host (.clk_i(clk_i), .go_i(go), .scl_o(host_scl), .sda_o(host_sda));
	initial forever #5 clk_i = ~clk_i;
	task cyc(input integer n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Holds the strobe high so back-to-back writes never toggle it twice
	task wr(input logic [4:0] a, input logic [15:0] d);
		wr_en_i = 1;
		wr_addr_i = a;
		wr_data_i = d;
		case (a)
			5'h00: vol[33:22] = d[11:0];
			5'h01: vol[21:10] = d[11:0];
			5'h08: vol[9:6] = d[3:0];
			5'h09: vol[5:2] = d[3:0];
			5'h0a: vol[1:0] = d[9:8];
			default: ;
		endcase
		cyc(1);
	endtask
	task rdy;
		for (i = 0; i < 300 && serial_ready_o !== 1'b1; i++)
			cyc(1);
		`CHK("ready", 1'b1, serial_ready_o)
	endtask
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			mismatches++;
			print_verdict;
		end
	end
	initial
	begin
		i = $urandom(69);
		cyc(4);
		rst_b_i = 1;
		rdy;
		vol = {12'h7ff, 12'h7ff, 10'h000};
		`CHK("defaults", vol, act_all)
		`CHK("status", 1'b1, reset_status_o)
		`CHK("pointer", 5'h00, addr_ptr_o)
		$display("test power-up done");
		output_update_latch_n_i = 1;
		cyc(8);
		act = vol;
		for (i = 0; i < 6; i++)
		begin
			r = 16'($urandom);
			wr(adr[i], (adr[i] == 5'h0a) ? (r & 16'h0300) : r);
		end
		wr_en_i = 0;
		cyc(6);
		`CHK("held", act, act_all)
		rd_addr_i = 5'h0a;
		cyc(2);
		`CHK("gain read", {6'h00, vol[1:0], 8'h80}, rd_data_o)
		rd_addr_i = 5'h00;
		cyc(2);
		`CHK("wiper read", {4'h0, vol[33:22]}, rd_data_o)
		output_update_latch_n_i = 0;
		cyc(8);
		`CHK("latched", vol, act_all)
		$display("test latch high done");
		for (i = 0; i < 4; i++)
		begin
			r = 16'($urandom);
			wr(5'h00, r);
			wr(5'h01, ~r);
			wr_en_i = 0;
			cyc(3);
			`CHK("live", vol, act_all)
		end
		$display("test latch low done");
		clr_status_i = 1;
		go = 1;
		cyc(1);
		clr_status_i = 0;
		for (i = 0; i < 4; i++)
		begin
			{address_select_pin_one_i, address_select_pin_zero_i} = i[1:0];
			cyc(6);
			`CHK("pins", {5'h18, i[1:0]}, target_addr_o)
		end
		cyc(80);
		`CHK("status clear", 1'b0, reset_status_o)
		`CHK("bus lines", 2'b00, {scl_oe_o, sda_oe_o})
		`CHK("last ack bit", 1'b1, sda_o)
		nv_wr_req_i = 1;
		cyc(4);
		`CHK("no hv", 1'b0, nv_wr_en_o)
		high_voltage_program_pin_i = 1;
		cyc(6);
		`CHK("hv", 1'b1, nv_wr_en_o)
		$display("test pins done");
		supply_drop_reset_event_i = 1;
		nv_programmed_i = 1;
		{nv_wiper0_i, nv_wiper1_i} = 24'($urandom);
		{nv_ref_sel_i, nv_pd_sel_i, nv_gain_i} = 10'($urandom);
		wr(5'h00, 16'h0123);
		wr_en_i = 0;
		cyc(2);
		`CHK("forced", {24'h0, 8'h0f, 2'h0}, act_all)
		`CHK("analog off", 1'b0, analog_on_o)
		`CHK("gated", 2'b00, {serial_ready_o, nv_wr_en_o})
		supply_drop_reset_event_i = 0;
		high_voltage_program_pin_i = 0;
		nv_wr_req_i = 0;
		rdy;
		vol = {nv_wiper0_i, nv_wiper1_i, nv_ref_sel_i, nv_pd_sel_i, nv_gain_i};
		`CHK("reloaded", vol, act_all)
		`CHK("status again", 1'b1, reset_status_o)
		$display("test brown-out done");
		print_verdict;
	end
endmodule // dlc_core_bench
`default_nettype wire

// >>> dv/dlc_core_properties.sv
// Port checks for the DAC latch and reset control core
`timescale 1ns/1ns
`default_nettype none
module dlc_core_properties (
	// Clock, reset and inputs
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic supply_drop_reset_event_i,
	input wire logic output_update_latch_n_i,
	input wire logic high_voltage_program_pin_i,
	input wire logic address_select_pin_zero_i,
	input wire logic address_select_pin_one_i,
	input wire logic wr_en_i,
	input wire logic [4:0] wr_addr_i,
	input wire logic [15:0] wr_data_i,
	input wire logic [4:0] rd_addr_i,
	// Outputs
	input wire logic [15:0] rd_data_o,
	input wire logic scl_oe_o,
	input wire logic serial_ready_o,
	input wire logic reset_status_o,
	input wire logic nv_wr_en_o,
	input wire logic [4:0] addr_ptr_o,
	input wire logic [6:0] target_addr_o,
	input wire logic [11:0] act_wiper0_o,
	input wire logic [3:0] act_ref_sel_o,
	input wire logic [3:0] act_pd_sel_o,
	input wire logic [1:0] act_gain_o,
	input wire logic analog_on_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// Eight cycles cover the synchroniser latency
	AST_LATCH_HOLD: assert property ((output_update_latch_n_i && serial_ready_o)[*8] |->
		$stable(act_wiper0_o) && $stable(act_gain_o)) else $error("outputs moved with latch high");
	AST_LATCH_COPY: assert property ((!output_update_latch_n_i && !wr_en_i && serial_ready_o &&
		rd_addr_i == 5'h00)[*8] |-> act_wiper0_o == rd_data_o[11:0]) else $error("stored not copied");
	AST_LATCH_LIVE: assert property ((!output_update_latch_n_i)[*6] ##0 (wr_en_i && serial_ready_o &&
		wr_addr_i == 5'h00 && !supply_drop_reset_event_i) ##1 (!output_update_latch_n_i &&
		!supply_drop_reset_event_i)[*2] |-> act_wiper0_o == $past(wr_data_i[11:0], 2))
		else $error("write did not reach output");
	AST_SCL_NEVER: assert property (!scl_oe_o) else $error("serial clock driven");
	AST_ADDR_PINS: assert property ((serial_ready_o && $stable({address_select_pin_one_i,
		address_select_pin_zero_i}))[*6] |-> target_addr_o[1:0] == {address_select_pin_one_i,
		address_select_pin_zero_i}) else $error("address pins ignored");
	AST_READY_SETS: assert property ($rose(serial_ready_o) |-> reset_status_o &&
		addr_ptr_o == 5'h00) else $error("status or pointer wrong at ready");
	AST_DELAY: assert property ($rose(rst_b_i) |-> (!serial_ready_o)[*4] ##[1:1000]
		serial_ready_o) else $error("reset delay wrong");
	AST_BROWN_GATE: assert property (supply_drop_reset_event_i[*2] |-> !serial_ready_o &&
		!nv_wr_en_o) else $error("interface alive in brown-out");
	AST_BROWN_FORCE: assert property (supply_drop_reset_event_i[*3] |-> act_pd_sel_o == 4'hf &&
		act_wiper0_o == 12'h000 && act_ref_sel_o == 4'h0 && act_gain_o == 2'h0 && !analog_on_o)
		else $error("brown-out state wrong");
	AST_HV_GATE: assert property ((!high_voltage_program_pin_i)[*6] |-> !nv_wr_en_o)
		else $error("program without high voltage");
	cover property (supply_drop_reset_event_i[*3]);
	cover property ($fell(output_update_latch_n_i));
	cover property (wr_en_i && serial_ready_o);
endmodule // dlc_core_properties
bind dlc_core dlc_core_properties u_dlc_core_properties (.*);
`default_nettype wire

// >>> dv/dlc_i2c_host.sv
// Behavioural serial bus controller sending one byte
`timescale 1ns/1ns
`default_nettype none
module dlc_i2c_host (
	// Clock and trigger
	input wire logic clk_i,
	input wire logic go_i,
	// Bus lines, low pulls the wire down
	output logic scl_o,
	output logic sda_o
);
	task tick;
		repeat (4) @(posedge clk_i);
		#1;
	endtask
	initial
	begin
		scl_o = 1;
		sda_o = 1;
		@(posedge go_i);
		sda_o = 0;
		tick;
		for (int k = 0; k < 9; k++)
		begin
			scl_o = 0;
			sda_o = (k < 8) ? k[0] : 1'b1;
			tick;
			scl_o = 1;
			tick;
		end
		scl_o = 0;
		sda_o = 0;
		tick;
		scl_o = 1;
		tick;
		sda_o = 1;
	end
endmodule // dlc_i2c_host
`default_nettype wire

// >>> src/dlc_core.v
// DAC latch, power-up and brown-out reset control core
`timescale 1ns/1ns
`default_nettype none
`include "dlc_defines.vh"
module dlc_core #(
	parameter [1:0] RESOLUTION = `DLC_RES_12,
	parameter HAS_NVM = 1'b1,
	parameter PORD_CYCLES = `DLC_PORD_CYC,
	// Arbitrary neutral base address
	parameter [6:0] SLAVE_BASE = `DLC_SLV_BASE
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_b_i,
	// Supply monitor
	input wire supply_drop_reset_event_i,
	// Pins
	input wire output_update_latch_n_i,
	input wire high_voltage_program_pin_i,
	input wire address_select_pin_zero_i,
	input wire address_select_pin_one_i,
	input wire scl_i,
	input wire sda_i,
	output reg sda_o,
	output reg sda_oe_o,
	output reg scl_oe_o,
	// Nonvolatile power-up values
	input wire nv_programmed_i,
	input wire [11:0] nv_wiper0_i,
	input wire [11:0] nv_wiper1_i,
	input wire [3:0] nv_ref_sel_i,
	input wire [3:0] nv_pd_sel_i,
	input wire [1:0] nv_gain_i,
	input wire [1:0] nv_addr_bits_i,
	// Volatile write port from command decoder
	input wire wr_en_i,
	input wire [4:0] wr_addr_i,
	input wire [15:0] wr_data_i,
	input wire clr_status_i,
	input wire nv_wr_req_i,
	// Read port
	input wire [4:0] rd_addr_i,
	output reg [15:0] rd_data_o,
	// Status
	output reg reset_status_o,
	output reg serial_ready_o,
	output reg nv_wr_en_o,
	output reg [4:0] addr_ptr_o,
	output reg [6:0] target_addr_o,
	// Active output settings
	output reg [11:0] act_wiper0_o,
	output reg [11:0] act_wiper1_o,
	output reg [3:0] act_ref_sel_o,
	output reg [3:0] act_pd_sel_o,
	output reg [1:0] act_gain_o,
	output reg analog_on_o
);
	reg rs1_q;
	reg rst_n;
	reg [1:0] st_q;
	reg [31:0] cnt_q;
	reg [11:0] vw0_q;
	reg [11:0] vw1_q;
	reg [3:0] vref_q;
	reg [3:0] vpd_q;
	reg [1:0] vgain_q;
	reg [4:0] ptr_q;
	reg sda_p1_q;
	reg sda_p2_q;
	reg scl_prev_q;
	wire lat_n;
	wire scl_s;
	wire sda_s;
	wire hv_s, a0_s, a1_s;

	// Mask a code to the selected resolution
	function [11:0] res_mask;
		input [11:0] v;
		begin
			case (RESOLUTION)
				`DLC_RES_8: res_mask = {4'h0, v[7:0]};
				`DLC_RES_10: res_mask = {2'h0, v[9:0]};
				default: res_mask = v;
			endcase
		end
	endfunction

	function [11:0] mid_code;
		input [1:0] r;
		begin
			case (r)
				`DLC_RES_8: mid_code = `DLC_MID_8;
				`DLC_RES_10: mid_code = `DLC_MID_10;
				default: mid_code = `DLC_MID_12;
			endcase
		end
	endfunction

	// Reset release through two flip-flops
	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			rs1_q <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rs1_q <= 1'b1;
			rst_n <= rs1_q;
		end
	end

	dlc_sync3 #(.RESET_VAL(1'b1)) u_lat (
		.clk_i(clk_i),
		.rst_b_i(rst_n),
		.async_i(output_update_latch_n_i),
		.sync_o(lat_n)
	);
	dlc_sync3 #(.RESET_VAL(1'b1)) u_scl (
		.clk_i(clk_i),
		.rst_b_i(rst_n),
		.async_i(scl_i),
		.sync_o(scl_s)
	);
	dlc_sync3 #(.RESET_VAL(1'b1)) u_sda (
		.clk_i(clk_i),
		.rst_b_i(rst_n),
		.async_i(sda_i),
		.sync_o(sda_s)
	);
	// Slow pins pass the same filter so a one-cycle glitch never reaches the logic
	dlc_sync3 #(.RESET_VAL(1'b0)) u_hv (
		.clk_i(clk_i), .rst_b_i(rst_n),
		.async_i(high_voltage_program_pin_i), .sync_o(hv_s));
	dlc_sync3 #(.RESET_VAL(1'b0)) u_a0 (
		.clk_i(clk_i), .rst_b_i(rst_n),
		.async_i(address_select_pin_zero_i), .sync_o(a0_s));
	dlc_sync3 #(.RESET_VAL(1'b0)) u_a1 (
		.clk_i(clk_i), .rst_b_i(rst_n),
		.async_i(address_select_pin_one_i), .sync_o(a1_s));

	// Reset sequencing and volatile state
	always @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q <= `DLC_ST_RESET;
			cnt_q <= 32'd0;
			vw0_q <= `DLC_WIPER_CLEAR;
			vw1_q <= `DLC_WIPER_CLEAR;
			vref_q <= 4'h0;
			vpd_q <= {`DLC_PD_FORCED, `DLC_PD_FORCED};
			vgain_q <= 2'h0;
			ptr_q <= `DLC_ADDR_ZERO;
			reset_status_o <= 1'b0;
			serial_ready_o <= 1'b0;
		end
		else
		begin
			case (st_q)
				`DLC_ST_RESET:
				begin
					if (HAS_NVM && nv_programmed_i)
					begin
						vw0_q <= res_mask(nv_wiper0_i);
						vw1_q <= res_mask(nv_wiper1_i);
						vref_q <= nv_ref_sel_i;
						vpd_q <= nv_pd_sel_i;
						vgain_q <= nv_gain_i;
					end
					else
					begin
						vw0_q <= mid_code(RESOLUTION);
						vw1_q <= mid_code(RESOLUTION);
						vref_q <= 4'h0;
						vpd_q <= 4'h0;
						vgain_q <= 2'h0;
					end
					reset_status_o <= 1'b1;
					ptr_q <= `DLC_ADDR_ZERO;
					cnt_q <= 32'd0;
					st_q <= supply_drop_reset_event_i ? `DLC_ST_BROWN : `DLC_ST_DELAY;
				end
				`DLC_ST_DELAY:
				begin
					if (supply_drop_reset_event_i)
						st_q <= `DLC_ST_BROWN;
					else if (cnt_q >= PORD_CYCLES - 1)
					begin
						serial_ready_o <= 1'b1;
						st_q <= `DLC_ST_RUN;
					end
					cnt_q <= cnt_q + 32'd1;
				end
				`DLC_ST_RUN:
				begin
					if (supply_drop_reset_event_i)
					begin
						serial_ready_o <= 1'b0;
						vpd_q <= {`DLC_PD_FORCED, `DLC_PD_FORCED};
						vw0_q <= `DLC_WIPER_CLEAR;
						vw1_q <= `DLC_WIPER_CLEAR;
						vref_q <= 4'h0;
						vgain_q <= 2'h0;
						st_q <= `DLC_ST_BROWN;
					end
					else if (wr_en_i)
					begin
						ptr_q <= wr_addr_i;
						case (wr_addr_i)
							5'h00: vw0_q <= res_mask(wr_data_i[11:0]);
							5'h01: vw1_q <= res_mask(wr_data_i[11:0]);
							5'h08: vref_q <= wr_data_i[3:0];
							5'h09: vpd_q <= wr_data_i[3:0];
							5'h0a: vgain_q <= wr_data_i[9:8];
							default: ptr_q <= wr_addr_i;
						endcase
					end
					if (clr_status_i && !supply_drop_reset_event_i)
						reset_status_o <= 1'b0;
				end
				`DLC_ST_BROWN:
				begin
					// Recovery: supply restored acts as a fresh power-up
					if (!supply_drop_reset_event_i)
						st_q <= `DLC_ST_RESET;
				end
				default: st_q <= `DLC_ST_RESET;
			endcase
		end
	end

	// Active settings: transfer while latch low
	always @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			act_wiper0_o <= `DLC_WIPER_CLEAR;
			act_wiper1_o <= `DLC_WIPER_CLEAR;
			act_ref_sel_o <= 4'h0;
			act_pd_sel_o <= {`DLC_PD_FORCED, `DLC_PD_FORCED};
			act_gain_o <= 2'h0;
			analog_on_o <= 1'b0;
		end
		else
		begin
			// Brown-out overrides latch so the outputs are safe two clocks after the event
			if (st_q == `DLC_ST_BROWN || st_q == `DLC_ST_RESET)
			begin
				act_pd_sel_o <= {`DLC_PD_FORCED, `DLC_PD_FORCED};
				act_wiper0_o <= `DLC_WIPER_CLEAR;
				act_wiper1_o <= `DLC_WIPER_CLEAR;
				act_ref_sel_o <= 4'h0;
				act_gain_o <= 2'h0;
				analog_on_o <= 1'b0;
			end
			else if (!lat_n)
			begin
				act_wiper0_o <= vw0_q;
				act_wiper1_o <= vw1_q;
				act_ref_sel_o <= vref_q;
				act_pd_sel_o <= vpd_q;
				act_gain_o <= vgain_q;
				analog_on_o <= 1'b1;
			end
		end
	end

	// Target address, read data, serial pin drive
	always @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			target_addr_o <= 7'h00;
			rd_data_o <= 16'h0000;
			addr_ptr_o <= `DLC_ADDR_ZERO;
			nv_wr_en_o <= 1'b0;
			sda_o <= 1'b0;
			sda_oe_o <= 1'b0;
			scl_oe_o <= 1'b0;
			sda_p1_q <= 1'b0;
			sda_p2_q <= 1'b0;
			scl_prev_q <= 1'b1;
		end
		else
		begin
			target_addr_o <= {SLAVE_BASE[6:2], a1_s, a0_s};
			addr_ptr_o <= ptr_q;
			nv_wr_en_o <= HAS_NVM && nv_wr_req_i && hv_s
				&& serial_ready_o && !supply_drop_reset_event_i;
			case (rd_addr_i)
				5'h00: rd_data_o <= {4'h0, vw0_q};
				5'h01: rd_data_o <= {4'h0, vw1_q};
				5'h08: rd_data_o <= {12'h000, vref_q};
				5'h09: rd_data_o <= {12'h000, vpd_q};
				5'h0a: rd_data_o <= {6'h00, vgain_q, reset_status_o, 7'h00};
				5'h1a: rd_data_o <= {6'h00, nv_gain_i, 1'b0, SLAVE_BASE[6:2],
					nv_addr_bits_i};
				default: rd_data_o <= 16'h0000;
			endcase
			scl_oe_o <= 1'b0;
			scl_prev_q <= scl_s;
			if (scl_s && !scl_prev_q)
				sda_p1_q <= sda_s;
			// release data line only after falling edge
			if (!scl_s && scl_prev_q)
			begin
				sda_p2_q <= sda_p1_q;
				sda_oe_o <= 1'b0;
			end
			sda_o <= sda_p2_q;
		end
	end
endmodule // dlc_core
`default_nettype wire

// >>> src/dlc_defines.vh
// Constants for the DAC latch and reset control core
`ifndef DLC_DEFINES_VH
`define DLC_DEFINES_VH
`define DLC_RES_8 2'd0
`define DLC_RES_10 2'd1
`define DLC_RES_12 2'd2
`define DLC_WIPER_W 12
`define DLC_ADDR_ZERO 5'h00
`define DLC_PD_FORCED 2'h3
`define DLC_WIPER_CLEAR 12'h000
`define DLC_MID_8 12'h07f
`define DLC_MID_10 12'h1ff
`define DLC_MID_12 12'h7ff
`define DLC_PORD_NS 1000
`define DLC_CLK_NS 10
`define DLC_PORD_CYC ((`DLC_PORD_NS + `DLC_CLK_NS - 1) / `DLC_CLK_NS)
`define DLC_ST_RESET 2'd0
`define DLC_ST_DELAY 2'd1
`define DLC_ST_RUN 2'd2
`define DLC_ST_BROWN 2'd3
`define DLC_SLV_BASE 7'h60
`endif

// >>> src/dlc_sync3.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module dlc_sync3 #(
	parameter RESET_VAL = 1'b0
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_b_i,
	// Signal
	input wire async_i,
	output reg sync_o
);
	reg s1_q;
	reg s2_q;
	reg s3_q;
	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			s1_q <= RESET_VAL;
			s2_q <= RESET_VAL;
			s3_q <= RESET_VAL;
			sync_o <= RESET_VAL;
		end
		else
		begin
			s1_q <= async_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// Change counts only once stages two and three agree
			if (s2_q == s3_q)
				sync_o <= s3_q;
		end
	end
endmodule // dlc_sync3
`default_nettype wire
